/* File: core/bpc_top.sv */
`timescale 1ns/1ps
module bpc_top (
	input  wire logic                       I_MCLK,
	input  wire logic                       I_RST,
	input  wire logic [bpc_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
	input  wire logic                       I_AVS_READ,
	input  wire logic                       I_AVS_WRITE,
	input  wire logic [31:0]                I_AVS_WRITEDATA,
	input  wire logic [3:0]                 I_AVS_BYTEENABLE,
	output logic [31:0]                     O_AVS_READDATA,
	output logic                            O_AVS_WAITREQUEST,
	input  wire bpc_pkg::bpc_nib_s          I_RX,
	output bpc_pkg::bpc_nib_s               O_TX,
	output logic                            O_IRQ
);
	import bpc_pkg::*;

	localparam logic [16:0] PRE_LAST = 17'(PRE_NIBBLES - 1);
	localparam logic [16:0] SFD_LAST = 17'(NIB_PER_BYTE - 1);
	localparam logic [16:0] GAP_MUL  = 17'(GAP_UNIT_BYTES * NIB_PER_BYTE);

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	// Counter step: returns overflow hit and next value.
	function automatic logic [16:0] bump(input logic [15:0] cur, input logic [15:0] top,
		input logic inc, input logic sat);
		logic [16:0] r;
		r = {1'b0, cur};
		if (inc && cur == top) begin
			r = {1'b1, sat ? top : 16'h0000};
		end else if (inc) begin
			r = {1'b0, 16'(cur + 16'h0001)};
		end
		return r;
	endfunction

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic        ack_r;
	logic        req;
	logic        wr_go;
	logic [31:0] rd_val;
	logic [31:0] rdata_r;
	logic [15:0] pkt_len_r;
	logic [7:0]  gap_r;
	logic [1:0]  ctrl_r;
	logic [3:0]  irq_mask_r;
	logic [3:0]  irq_sts_r;
	logic        irq_r;
	logic        lock_p;
	logic        clr_p;

	// Every access waits exactly one cycle.
	assign req               = I_AVS_READ | I_AVS_WRITE;
	assign O_AVS_WAITREQUEST = req & ~ack_r;
	assign wr_go             = I_AVS_WRITE & ack_r;
	assign O_AVS_READDATA    = rdata_r;

	// Acknowledge flop, high for the single answering cycle.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Lock and clear strobes from writes of ones to the low status bits.
	assign lock_p = wr_go && I_AVS_ADDRESS == byte_addr(IDX_ERR_STS) && I_AVS_BYTEENABLE[0]
		&& (I_AVS_WRITEDATA[STS_LOCK_BIT] || I_AVS_WRITEDATA[STS_CLEAR_BIT]);
	assign clr_p  = lock_p && I_AVS_WRITEDATA[STS_CLEAR_BIT];

	// Software-written configuration registers.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			pkt_len_r  <= PKT_LEN_RST;
			gap_r      <= GAP_LEN_RST;
			ctrl_r     <= CTRL_RST;
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_go) begin
			if (I_AVS_ADDRESS == byte_addr(IDX_PKT_LEN)) begin
				if (I_AVS_BYTEENABLE[0]) pkt_len_r[7:0] <= I_AVS_WRITEDATA[7:0];
				if (I_AVS_BYTEENABLE[1]) pkt_len_r[15:8] <= I_AVS_WRITEDATA[15:8];
			end
			if (I_AVS_ADDRESS == byte_addr(IDX_GAP_LEN) && I_AVS_BYTEENABLE[0]) begin
				gap_r <= I_AVS_WRITEDATA[7:0];
			end
			if (I_AVS_ADDRESS == byte_addr(IDX_CTRL) && I_AVS_BYTEENABLE[0]) begin
				ctrl_r <= I_AVS_WRITEDATA[1:0];
			end
			if (I_AVS_ADDRESS == byte_addr(IDX_IRQ_MASK) && I_AVS_BYTEENABLE[0]) begin
				irq_mask_r <= I_AVS_WRITEDATA[3:0];
			end
		end
	end

	// ----------------------------------------
	// Checker front end
	// ----------------------------------------
	logic       sync_r;
	logic       half_r;
	logic [3:0] lo_r;
	logic [3:0] prev_r;
	logic       byte_vld;
	logic [7:0] rx_byte;
	logic [7:0] chk_byte;
	logic       err_hit;
	logic       frame_end;

	// Hunts the SFD, then pairs nibbles low first into bytes.
	always_ff @(posedge I_MCLK) begin
		if (I_RST || !I_RX.en) begin
			sync_r <= 1'b0;
			half_r <= 1'b0;
		end else if (!sync_r) begin
			sync_r <= I_RX.nib == SFD_BYTE[7:4] && prev_r == SFD_BYTE[3:0];
			half_r <= 1'b0;
		end else begin
			half_r <= ~half_r;
		end
	end

	// Nibble history for SFD detection and byte pairing.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			prev_r <= 4'h0;
			lo_r   <= 4'h0;
		end else begin
			prev_r <= I_RX.nib;
			if (!half_r) lo_r <= I_RX.nib;
		end
	end

	assign byte_vld  = I_RX.en & sync_r & half_r;
	assign rx_byte   = {I_RX.nib, lo_r};
	assign err_hit   = byte_vld && rx_byte != chk_byte;
	assign frame_end = sync_r & ~I_RX.en;

	// Local copy of the sequence, restarted by a counter clear.
	bpc_prbs_byte u_chk_prbs (
		.i_clk     (I_MCLK),
		.i_rst     (I_RST),
		.i_restart (clr_p),
		.i_advance (byte_vld),
		.o_byte    (chk_byte)
	);

	// ----------------------------------------
	// Checker counters
	// ----------------------------------------
	logic [15:0] byte_cnt_r;
	logic [7:0]  err_cnt_r;
	logic [15:0] pkt_cnt_r;
	logic [15:0] rd_byte_r;
	logic [7:0]  rd_err_r;
	logic        byte_ovf_r;
	logic        pkt_ovf_r;
	logic [16:0] byte_nxt;
	logic [16:0] err_nxt;
	logic [16:0] pkt_nxt;
	logic        sat;

	// Mode zero saturates, any other mode wraps.
	assign sat = ~ctrl_r[CTRL_MODE_BIT];

	// Next counter values with overflow hits.
	always_comb begin
		byte_nxt = bump(byte_cnt_r, 16'hFFFF, byte_vld, sat);
		err_nxt  = bump({8'h00, err_cnt_r}, 16'h00FF, err_hit, sat);
		pkt_nxt  = bump(pkt_cnt_r, 16'hFFFF, frame_end, sat);
	end

	// Live counters, restarted from zero by a clear strobe.
	always_ff @(posedge I_MCLK) begin
		if (I_RST || clr_p) begin
			byte_cnt_r <= BYTE_CNT_RST;
			err_cnt_r  <= ERR_CNT_RST;
			pkt_cnt_r  <= 16'h0000;
		end else begin
			byte_cnt_r <= byte_nxt[15:0];
			err_cnt_r  <= err_nxt[7:0];
			pkt_cnt_r  <= pkt_nxt[15:0];
		end
	end

	// Sticky overflow flags; a new overflow wins over a clear.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			byte_ovf_r <= 1'b0;
			pkt_ovf_r  <= 1'b0;
		end else begin
			byte_ovf_r <= byte_nxt[16] | (byte_ovf_r & ~clr_p);
			pkt_ovf_r  <= pkt_nxt[16] | (pkt_ovf_r & ~clr_p);
		end
	end

	// Readable snapshots, loaded only by a lock strobe.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rd_byte_r <= BYTE_CNT_RST;
			rd_err_r  <= ERR_CNT_RST;
		end else if (lock_p) begin
			rd_byte_r <= byte_cnt_r;
			rd_err_r  <= err_cnt_r;
		end
	end

	// ----------------------------------------
	// Generator
	// ----------------------------------------
	bpc_gen_e    state_r;
	logic [16:0] cnt_r;
	logic [15:0] len_lat_r;
	logic [7:0]  gap_lat_r;
	logic [7:0]  gen_byte;
	logic        gen_go;
	logic        pay_last;
	logic        gap_last;
	logic        pkt_sent;
	bpc_nib_s    tx_r;

	assign gen_go   = ctrl_r[CTRL_GEN_EN_BIT] && pkt_len_r != 16'h0000;
	assign pay_last = cnt_r == 17'({len_lat_r, 1'b0} - 17'h00001);
	assign gap_last = cnt_r == 17'(17'(gap_lat_r) * GAP_MUL - 17'h00001);
	assign pkt_sent = state_r == GEN_PAY && pay_last;

	// Sequence of preamble, SFD, payload and gap; length and gap latched per packet.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			state_r   <= GEN_IDLE;
			cnt_r     <= 17'h00000;
			len_lat_r <= PKT_LEN_RST;
			gap_lat_r <= GAP_LEN_RST;
		end else begin
			cnt_r <= 17'(cnt_r + 17'h00001);
			case (state_r)
				GEN_IDLE: begin
					cnt_r <= 17'h00000;
					if (gen_go) begin
						state_r   <= GEN_PRE;
						len_lat_r <= pkt_len_r;
						gap_lat_r <= gap_r;
					end
				end
				GEN_PRE: begin
					if (cnt_r == PRE_LAST) begin
						state_r <= GEN_SFD;
						cnt_r   <= 17'h00000;
					end
				end
				GEN_SFD: begin
					if (cnt_r == SFD_LAST) begin
						state_r <= GEN_PAY;
						cnt_r   <= 17'h00000;
					end
				end
				GEN_PAY: begin
					if (pay_last) begin
						cnt_r <= 17'h00000;
						if (gap_lat_r != 8'h00) begin
							state_r <= GEN_GAP;
						end else begin
							state_r   <= gen_go ? GEN_PRE : GEN_IDLE;
							len_lat_r <= pkt_len_r;
							gap_lat_r <= gap_r;
						end
					end
				end
				GEN_GAP: begin
					if (gap_last) begin
						cnt_r     <= 17'h00000;
						state_r   <= gen_go ? GEN_PRE : GEN_IDLE;
						len_lat_r <= pkt_len_r;
						gap_lat_r <= gap_r;
					end
				end
				default: begin
					state_r <= GEN_IDLE;
				end
			endcase
		end
	end

	// Free-running payload sequence, advanced after each high nibble.
	bpc_prbs_byte u_gen_prbs (
		.i_clk     (I_MCLK),
		.i_rst     (I_RST),
		.i_restart (1'b0),
		.i_advance (state_r == GEN_PAY && cnt_r[0]),
		.o_byte    (gen_byte)
	);

	// Registered nibble output, low nibble of each byte first.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			tx_r <= '0;
		end else begin
			case (state_r)
				GEN_PRE: tx_r <= '{en: 1'b1, nib: PRE_NIB};
				GEN_SFD: tx_r <= '{en: 1'b1, nib: cnt_r[0] ? SFD_BYTE[7:4] : SFD_BYTE[3:0]};
				GEN_PAY: tx_r <= '{en: 1'b1, nib: cnt_r[0] ? gen_byte[7:4] : gen_byte[3:0]};
				default: tx_r <= '0;
			endcase
		end
	end
	assign O_TX = tx_r;

	// ----------------------------------------
	// Interrupts and read data
	// ----------------------------------------
	logic [3:0] irq_ev;
	logic [3:0] irq_w1c;

	assign irq_ev = {pkt_sent, pkt_nxt[16], byte_nxt[16], err_hit};
	assign irq_w1c = (wr_go && I_AVS_ADDRESS == byte_addr(IDX_IRQ_STS) && I_AVS_BYTEENABLE[0])
		? I_AVS_WRITEDATA[3:0] : 4'h0;

	// Sticky event bits, set wins over a write of one.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			irq_sts_r <= 4'h0;
			irq_r     <= 1'b0;
		end else begin
			irq_sts_r <= irq_ev | (irq_sts_r & ~irq_w1c);
			irq_r     <= |(irq_sts_r & irq_mask_r);
		end
	end
	assign O_IRQ = irq_r;

	// Read mux; reserved bits and unmapped addresses read zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		case (I_AVS_ADDRESS)
			byte_addr(IDX_BYTE_CNT): rd_val[15:0] = rd_byte_r;
			byte_addr(IDX_ERR_STS): begin
				rd_val[7:0]             = rd_err_r;
				rd_val[STS_BYTE_OVF_BIT] = byte_ovf_r;
				rd_val[STS_PKT_OVF_BIT]  = pkt_ovf_r;
			end
			byte_addr(IDX_PKT_LEN):  rd_val[15:0] = pkt_len_r;
			byte_addr(IDX_GAP_LEN):  rd_val[7:0] = gap_r;
			byte_addr(IDX_CTRL):     rd_val[1:0] = ctrl_r;
			byte_addr(IDX_IRQ_STS):  rd_val[3:0] = irq_sts_r;
			byte_addr(IDX_IRQ_MASK): rd_val[3:0] = irq_mask_r;
			default:                 rd_val = 32'h0000_0000;
		endcase
	end

	// Read data captured in the waiting cycle, stands at the answering edge.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rdata_r <= 32'h0000_0000;
		end else if (I_AVS_READ && !ack_r) begin
			rdata_r <= rd_val;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [16:0] pay_n;
	logic [16:0] gap_n;

	// Cycle counts of the payload and gap states.
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			pay_n <= 17'h00000;
			gap_n <= 17'h00000;
		end else begin
			pay_n <= state_r == GEN_PAY ? 17'(pay_n + 17'h00001) : 17'h00000;
			gap_n <= state_r == GEN_GAP ? 17'(gap_n + 17'h00001) : 17'h00000;
		end
	end

	sequence s_pre;
		O_TX.nib == PRE_NIB [*8] ##1 O_TX.nib == PRE_NIB [*5];
	endsequence
	sequence s_sfd;
		O_TX.nib == SFD_BYTE[3:0] ##1 O_TX.nib == SFD_BYTE[7:4];
	endsequence

	property p_bus;
		req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest held too long");
	property p_clear;
		clr_p |=> byte_cnt_r == 16'h0000 && err_cnt_r == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("counters not cleared");
	property p_frozen;
		!lock_p |=> $stable(rd_byte_r) && $stable(rd_err_r);
	endproperty
	a_frozen: assert property (p_frozen) else $error("snapshot moved");
	property p_lock;
		lock_p |=> rd_byte_r == $past(byte_cnt_r) && rd_err_r == $past(err_cnt_r);
	endproperty
	a_lock: assert property (p_lock) else $error("lock missed");
	property p_byte_sat;
		sat && !clr_p && byte_cnt_r == 16'hFFFF |=> byte_cnt_r == 16'hFFFF;
	endproperty
	a_byte_sat: assert property (p_byte_sat) else $error("byte count wrapped");
	property p_err_sat;
		sat && !clr_p && err_cnt_r == 8'hFF |=> err_cnt_r == 8'hFF;
	endproperty
	a_err_sat: assert property (p_err_sat) else $error("error count wrapped");
	property p_wrap;
		!sat && !clr_p && byte_vld && byte_cnt_r == 16'hFFFF |=> byte_cnt_r == 16'h0000
			&& byte_ovf_r;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap or flag wrong");
	property p_flag_hold;
		byte_ovf_r && pkt_ovf_r && !clr_p |=> byte_ovf_r && pkt_ovf_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
	property p_preamble;
		$rose(O_TX.en) |-> s_pre ##1 s_sfd;
	endproperty
	a_preamble: assert property (p_preamble) else $error("bad preamble");
	property p_length;
		$fell(state_r == GEN_PAY) |-> pay_n == {$past(len_lat_r), 1'b0};
	endproperty
	a_length: assert property (p_length) else $error("bad packet length");
	property p_gap;
		$fell(state_r == GEN_GAP) |-> gap_n == 17'(17'($past(gap_lat_r)) * GAP_MUL);
	endproperty
	a_gap: assert property (p_gap) else $error("bad gap length");

endmodule

/* File: core/bpc_pkg.sv */
// What this block does
// - Sixteen-bit read-only received byte counter, reset zero.
// - Lock writes freeze the readable byte count.
// - Count mode zero: byte counter saturates.
// - Eight-bit read-only error byte counter.
// - Count mode zero: error counter saturates.
// - Bit 10 flags packet counter overflow.
// - Bit 9 flags byte counter overflow.
// - Overflow flags stay until clear write.
// - Writing bit 0 locks counters, no clear.
// - Writing bit 1 locks then clears counters.
// - Packet payload length equals length register.
// - Thirteen preamble nibbles five, then SFD.
// - Gap field sets idle between packets.
// - Gap equals four bytes per field step.
package bpc_pkg;

	// ----------------------------------------
	// Register indices; byte address is index times four.
	// ----------------------------------------
	localparam int         ADDR_W       = 10;
	localparam logic [7:0] IDX_BYTE_CNT = 8'h71;
	localparam logic [7:0] IDX_ERR_STS  = 8'h72;
	localparam logic [7:0] IDX_PKT_LEN  = 8'h7B;
	localparam logic [7:0] IDX_GAP_LEN  = 8'h7C;
	localparam logic [7:0] IDX_CTRL     = 8'h80;
	localparam logic [7:0] IDX_IRQ_STS  = 8'h81;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h82;

	// ----------------------------------------
	// Field positions.
	// ----------------------------------------
	localparam int STS_LOCK_BIT     = 0;
	localparam int STS_CLEAR_BIT    = 1;
	localparam int STS_BYTE_OVF_BIT = 9;
	localparam int STS_PKT_OVF_BIT  = 10;
	localparam int CTRL_GEN_EN_BIT  = 0;
	localparam int CTRL_MODE_BIT    = 1;
	localparam int IRQ_ERR_BIT      = 0;
	localparam int IRQ_BYTE_OVF_BIT = 1;
	localparam int IRQ_PKT_OVF_BIT  = 2;
	localparam int IRQ_PKT_SENT_BIT = 3;
	localparam int IRQ_W            = 4;

	// ----------------------------------------
	// Reset values.
	// ----------------------------------------
	localparam logic [15:0] BYTE_CNT_RST = 16'h0000;
	localparam logic [7:0]  ERR_CNT_RST  = 8'h00;
	localparam logic [15:0] PKT_LEN_RST  = 16'h05DC;
	localparam logic [7:0]  GAP_LEN_RST  = 8'h7D;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

	// ----------------------------------------
	// Frame format and sequence constants.
	// ----------------------------------------
	localparam int          PRE_NIBBLES    = 13;
	localparam logic [3:0]  PRE_NIB        = 4'h5;
	localparam logic [7:0]  SFD_BYTE       = 8'hD5;
	localparam int          GAP_UNIT_BYTES = 4;
	localparam int          NIB_PER_BYTE   = 2;
	localparam logic [14:0] PRBS_SEED      = 15'h7FFF;

	// One nibble of the test stream with its enable.
	typedef struct packed {
		logic       en;
		logic [3:0] nib;
	} bpc_nib_s;

	// Generator sequence states.
	typedef enum logic [2:0] {
		GEN_IDLE = 3'b000,
		GEN_PRE  = 3'b001,
		GEN_SFD  = 3'b010,
		GEN_PAY  = 3'b011,
		GEN_GAP  = 3'b100
	} bpc_gen_e;

	// Byte address of a register index.
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

endpackage

/* File: core/bpc_prbs_byte.sv */
`timescale 1ns/1ps
module bpc_prbs_byte (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_restart,
	input  wire logic       i_advance,
	output logic [7:0]      o_byte
);
	import bpc_pkg::*;

	logic [14:0] lfsr_r;

	// Steps the x^15 + x^14 + 1 sequence by eight bits.
	function automatic logic [14:0] step8(input logic [14:0] s);
		logic [14:0] t;
		t = s;
		for (int i = 0; i < 8; i++) begin
			t = {t[13:0], t[14] ^ t[13]};
		end
		return t;
	endfunction

	// ----------------------------------------
	// Sequence register; restart wins over advance.
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst || i_restart) begin
			lfsr_r <= PRBS_SEED;
		end else if (i_advance) begin
			lfsr_r <= step8(lfsr_r);
		end
	end

	// The current byte comes straight from the register.
	assign o_byte = lfsr_r[7:0];

endmodule

/* File: bench/bpc_link_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Loopback path model
// ----------------------------------------
// Returns the test stream one cycle late and flips bit 0 of the low nibble of
// payload bytes until the commanded total of corrupted bytes has been reached.
module bpc_link_model (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [15:0]       i_corrupt_total,
	input  wire bpc_pkg::bpc_nib_s i_tx,
	output bpc_pkg::bpc_nib_s      o_rx
);
	import bpc_pkg::*;

	logic [15:0] idx_r;
	logic [15:0] done_r;
	logic        hit;

	// Nibble 15 of a frame is the first low payload nibble; odd positions are low nibbles.
	assign hit = i_tx.en && (idx_r >= 16'h000F) && idx_r[0] && (done_r < i_corrupt_total);

	// The idle line toggles every cycle so that stale data never looks valid.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rx   <= '0;
			idx_r  <= 16'h0000;
			done_r <= 16'h0000;
		end else begin
			o_rx.en  <= i_tx.en;
			o_rx.nib <= i_tx.en ? (i_tx.nib ^ {3'h0, hit}) : ~o_rx.nib;
			idx_r    <= i_tx.en ? idx_r + 16'h0001 : 16'h0000;
			if (hit) begin
				done_r <= done_r + 16'h0001;
			end
		end
	end
endmodule

/* File: bench/bpc_top_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
	$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module bpc_top_tb;
	import bpc_pkg::*;

	typedef struct packed {
		logic        wr;
		logic [7:0]  idx;
		logic [15:0] wd;
		logic [15:0] exp;
	} bpc_row_s;

	// Register rows: reset values, read-only and reserved places, a plain read-write.
	localparam bpc_row_s ROWS [0:8] = '{
		'{1'b0, IDX_BYTE_CNT, 16'h0000, 16'h0000},
		'{1'b0, IDX_ERR_STS, 16'h0000, 16'h0000},
		'{1'b0, IDX_PKT_LEN, 16'h0000, 16'h05DC},
		'{1'b0, IDX_GAP_LEN, 16'h0000, 16'h007D},
		'{1'b0, 8'hFF, 16'h0000, 16'h0000},
		'{1'b1, IDX_GAP_LEN, 16'hFFFF, 16'h00FF},
		'{1'b1, IDX_BYTE_CNT, 16'hFFFF, 16'h0000},
		'{1'b1, IDX_ERR_STS, 16'hFCFC, 16'h0000},
		'{1'b1, IDX_PKT_LEN, 16'hA5C3, 16'hA5C3}};

	logic              I_MCLK = 1'b0;
	logic              I_RST = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = 32'h0000_0000;
	logic [3:0]        avs_byteenable = 4'hF;
	logic [31:0]       O_AVS_READDATA;
	logic              O_AVS_WAITREQUEST;
	logic              O_IRQ;
	bpc_nib_s          rx;
	bpc_nib_s          O_TX;
	logic [15:0]       corrupt_total = 16'h0000;
	logic [15:0]       v;
	int                num_errors = 0;
	int                tests_run = 0;
	int                starts = 0;
	int                nibs = 0;
	int                last_len = 0;
	int                last_gap = 0;
	int                idle_cnt = 0;
	logic              hdr_bad = 1'b0;

	always #4 I_MCLK = ~I_MCLK;

	bpc_top u_bpc_top (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_AVS_ADDRESS(avs_address),
		.I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
		.I_AVS_BYTEENABLE(avs_byteenable), .O_AVS_READDATA(O_AVS_READDATA),
		.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_RX(rx), .O_TX(O_TX), .O_IRQ(O_IRQ));

	bpc_link_model u_bpc_link_model (.i_clk(I_MCLK), .i_rst(I_RST),
		.i_corrupt_total(corrupt_total), .i_tx(O_TX), .o_rx(rx));

	// Frame monitor: header nibbles, payload nibble count and idle gap before each frame.
	always @(posedge I_MCLK) begin
		if (O_TX.en === 1'b1) begin
			if (nibs == 0) begin
				starts++;
				last_gap = idle_cnt;
			end
			if (nibs < 15 && O_TX.nib !== ((nibs == 14) ? 4'hD : PRE_NIB)) hdr_bad = 1'b1;
			nibs++;
			idle_cnt = 0;
		end else begin
			if (nibs > 0) last_len = nibs - 15;
			nibs = 0;
			idle_cnt++;
		end
	end

	// One bus cycle: request held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
		output logic [15:0] rd);
		int n;
		@(posedge I_MCLK);
		avs_address   <= byte_addr(idx);
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_writedata <= {16'h0000, wd};
		n = 0;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (O_AVS_WAITREQUEST !== 1'b0);
		`CHK(n, 2)
		rd = O_AVS_READDATA[15:0];
		if (!wr) `CHK(O_AVS_READDATA[31:16], 16'h0000)
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
		logic [15:0] d;
		bus(1'b1, idx, wd, d);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [15:0] d);
		bus(1'b0, idx, 16'h0000, d);
	endtask

	// Enables the generator until frame n of this run starts, then lets it drain.
	task automatic run(input int n, input logic mode);
		int s0;
		int k;
		s0 = starts;
		wr(IDX_CTRL, {14'h0000, mode, 1'b1});
		for (k = 0; k < 20000 && starts < s0 + n; k++) @(posedge I_MCLK);
		wr(IDX_CTRL, {14'h0000, mode, 1'b0});
		for (k = 0; k < 20000 && idle_cnt < 40; k++) @(posedge I_MCLK);
	endtask

	task automatic rows(input int hi);
		for (int i = 0; i <= hi; i++) begin
			if (ROWS[i].wr) wr(ROWS[i].idx, ROWS[i].wd);
			rd(ROWS[i].idx, v);
			`CHK(v, ROWS[i].exp)
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the few thousand cycles that the sequence needs.
	initial begin
		repeat (60000) @(posedge I_MCLK);
		num_errors++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge I_MCLK);
		I_RST <= 1'b0;
		rows(8);
		$display("Register table test done");
		wr(IDX_PKT_LEN, 16'h0004);
		wr(IDX_GAP_LEN, 16'h0001);
		wr(IDX_ERR_STS, 16'h0002);
		wr(IDX_IRQ_MASK, 16'h0001);
		run(3, 1'b0);
		`CHK(hdr_bad, 1'b0)
		`CHK(last_len, 8)
		`CHK(last_gap, GAP_UNIT_BYTES * NIB_PER_BYTE)
		wr(IDX_ERR_STS, 16'h0001);
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'(starts * 4))
		rd(IDX_ERR_STS, v);
		`CHK(v, 16'h0000)
		`CHK(O_IRQ, 1'b0)
		rd(IDX_IRQ_STS, v);
		`CHK(v, 16'h0008)
		$display("Frame format and clean loopback test done");
		corrupt_total <= 16'h0002;
		run(2, 1'b0);
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'h000C)
		wr(IDX_ERR_STS, 16'h0001);
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'(starts * 4))
		rd(IDX_ERR_STS, v);
		`CHK(v, 16'h0002)
		`CHK(O_IRQ, 1'b1)
		wr(IDX_IRQ_MASK, 16'h0000);
		repeat (3) @(posedge I_MCLK);
		`CHK(O_IRQ, 1'b0)
		wr(IDX_IRQ_MASK, 16'h0001);
		repeat (3) @(posedge I_MCLK);
		`CHK(O_IRQ, 1'b1)
		wr(IDX_IRQ_STS, 16'h0001);
		repeat (3) @(posedge I_MCLK);
		`CHK(O_IRQ, 1'b0)
		$display("Error count, freeze and interrupt test done");
		wr(IDX_ERR_STS, 16'h0002);
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'(starts * 4))
		wr(IDX_ERR_STS, 16'h0001);
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'h0000)
		rd(IDX_ERR_STS, v);
		`CHK(v, 16'h0000)
		$display("Clear test done");
		@(posedge I_MCLK);
		I_RST         <= 1'b1;
		corrupt_total <= 16'h0000;
		repeat (2) @(posedge I_MCLK);
		I_RST <= 1'b0;
		rows(4);
		avs_byteenable <= 4'h1;
		wr(IDX_PKT_LEN, 16'hFF2C);
		rd(IDX_PKT_LEN, v);
		`CHK(v, 16'h052C)
		avs_byteenable <= 4'hF;
		wr(IDX_PKT_LEN, 16'h012C);
		wr(IDX_GAP_LEN, 16'h0001);
		wr(IDX_ERR_STS, 16'h0002);
		corrupt_total <= 16'h012C;
		run(1, 1'b0);
		wr(IDX_ERR_STS, 16'h0001);
		rd(IDX_ERR_STS, v);
		`CHK(v, 16'h00FF)
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'h012C)
		corrupt_total <= 16'h0258;
		run(1, 1'b1);
		wr(IDX_ERR_STS, 16'h0001);
		rd(IDX_ERR_STS, v);
		`CHK(v, 16'h002B)
		rd(IDX_BYTE_CNT, v);
		`CHK(v, 16'h0258)
		$display("Second reset, saturate and wrap test done");
		final_report();
	end
endmodule
